// File: turntable_full_auto_sequencer.sv
// full auto sequencer: return, end detector, lift, size ring and repeat
module turntable_full_auto_sequencer
  import turntable_pkg::*;
(
  input wire logic clock_i, // 200 MHz clock
  input wire logic rst_n_i, // power-on reset, active low
  input wire keys_s keys_i, // raw panel keys, high when pressed
  input wire logic arm_at_rest_i, // rest sensor, high at rest
  input wire logic lift_up_sw_i, // high when lift fully up
  input wire logic lift_lowered_i, // high when lift fully down
  input wire logic size_sensor_i, // selected size sensor blocked
  input wire logic end_sensor_i, // squared end-sensor signal
  output logic lift_motor_up_o, // drive lift upward
  output logic lift_motor_down_o, // drive lift downward
  output logic lead_in_drive_o, // carrier toward record
  output logic return_drive_o, // carrier toward rest
  output logic plunger_pulse_node_o, // plunger drive
  output logic platter_run_o, // platter motor on
  output logic locate_block_o, // inhibit manual locate
  output logic [1:0] size_sel_o, // size_count_bit1, size_count_bit0
  output leds_s leds_o // front-panel indicators
);
`include "turntable_regs.svh"

  localparam int unsigned DB_MAX = `DEBOUNCE_CYCLES;
  localparam int unsigned SS_MAX = `SS_BLOCK_CYCLES;
  localparam int unsigned WIN_MAX = `END_WINDOW_CYCLES;
  localparam int unsigned PL_MAX = `PLUNGER_CYCLES;
  localparam int unsigned RH_MAX = `REST_HOLD_CYCLES;
  localparam int unsigned ED_MAX = `END_EDGE_DELAY_CYCLES;

  // saturating-free counter step, shared by the 29-bit timers (start/stop block, rest hold, plunger, window)
  function automatic logic [28:0] step(input logic [28:0] c);
    step = c + 29'h1;
  endfunction

  // key conditioning: a key must hold steady before its state is taken
  logic [3:0] key_raw, key_stable_reg, key_prev_reg;
  logic [3:0] key_ev;
  logic [20:0] db_cnt_reg [4];
  assign key_raw = keys_i;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_stable_reg <= 4'h0;
      key_prev_reg <= 4'h0;
      for (int i = 0; i < 4; i++) db_cnt_reg[i] <= 21'h0;
    end else begin
      key_prev_reg <= key_stable_reg;
      for (int i = 0; i < 4; i++) begin
        if (key_raw[i] == key_stable_reg[i]) begin
          db_cnt_reg[i] <= 21'h0;
        end else if (db_cnt_reg[i] == 21'(DB_MAX - 1)) begin
          key_stable_reg[i] <= key_raw[i];
          db_cnt_reg[i] <= 21'h0;
        end else begin
          db_cnt_reg[i] <= db_cnt_reg[i] + 21'h1;
        end
      end
    end
  end
  assign key_ev = key_stable_reg & ~key_prev_reg; // one event per press
  wire ev_ss = key_ev[3];
  wire ev_lift = key_ev[2];
  wire ev_size = key_ev[1];
  wire ev_rep = key_ev[0];

  logic lead_in_reg, return_reg, repeat_reg, lift_up_reg;
  logic [1:0] size_reg;
  logic ss_block_reg;
  logic [28:0] ss_cnt_reg;
  logic plunger_reg, plunger_prev_reg;
  logic [28:0] pl_cnt_reg;
  logic descend;
  logic end_detect;
  logic rest_hold_reg;
  logic [28:0] rh_cnt_reg;
  logic size_prev_reg;
  wire auto_mode = lead_in_reg | return_reg;
  wire size_cross = size_sensor_i & ~size_prev_reg;

  // start/stop blocking: inputs ignored 1 ms after an automatic mode starts
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ss_cnt_reg <= 29'h0;
      ss_block_reg <= 1'b0;
    end else if (!auto_mode) begin
      ss_cnt_reg <= 29'h0;
      ss_block_reg <= 1'b0;
    end else if (!ss_block_reg) begin
      if (ss_cnt_reg == 29'(SS_MAX - 1)) ss_block_reg <= 1'b1;
      ss_cnt_reg <= step(ss_cnt_reg);
    end
  end

  // lead-in and return flip-flops; descend clears both
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lead_in_reg <= 1'b0;
      return_reg <= 1'b0;
    end else if (descend) begin
      lead_in_reg <= 1'b0;
      return_reg <= 1'b0;
    end else begin
      if (ev_ss && !ss_block_reg && arm_at_rest_i && !auto_mode) lead_in_reg <= 1'b1;
      if (ev_ss && !ss_block_reg && !arm_at_rest_i) return_reg <= 1'b1;
      else if (end_detect) return_reg <= 1'b1;
      else if (rest_hold_reg && rh_cnt_reg == 29'(RH_MAX - 1)) return_reg <= 1'b0;
    end
  end

  // rest hold: delay before return clears, carrier kept against rest
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rest_hold_reg <= 1'b0;
      rh_cnt_reg <= 29'h0;
    end else if (return_reg && arm_at_rest_i && lift_up_reg && !rest_hold_reg) begin
      rest_hold_reg <= 1'b1;
      rh_cnt_reg <= 29'h0;
    end else if (rest_hold_reg) begin
      if (!return_reg || rh_cnt_reg == 29'(RH_MAX - 1)) rest_hold_reg <= 1'b0;
      rh_cnt_reg <= step(rh_cnt_reg);
    end
  end

  // plunger one-shot; fires on lead-in, or return only with repeat on
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      plunger_reg <= 1'b0;
      pl_cnt_reg <= 29'h0;
      size_prev_reg <= 1'b0;
      plunger_prev_reg <= 1'b0;
    end else begin
      size_prev_reg <= size_sensor_i;
      plunger_prev_reg <= plunger_reg;
      if (plunger_reg) begin
        if (pl_cnt_reg == 29'(PL_MAX - 1)) plunger_reg <= 1'b0;
        pl_cnt_reg <= step(pl_cnt_reg);
      end else if (size_cross && (lead_in_reg || (return_reg && repeat_reg))) begin
        plunger_reg <= 1'b1;
        pl_cnt_reg <= 29'h0;
      end
    end
  end
  assign descend = plunger_prev_reg & ~plunger_reg; // falling edge

  // lift flip-flop: key toggles, automatic clear/preset override
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lift_up_reg <= 1'b1;
    end else if (descend) begin
      lift_up_reg <= 1'b0;
    end else if (auto_mode && !plunger_reg) begin
      lift_up_reg <= 1'b1;
    end else if (ev_lift && !auto_mode) begin
      lift_up_reg <= ~lift_up_reg;
    end
  end

  // repeat flip-flop: cleared by start/stop off rest, toggle blocked during return
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      repeat_reg <= 1'b0;
    end else if (ev_ss && !ss_block_reg && !arm_at_rest_i) begin
      repeat_reg <= 1'b0;
    end else if (ev_rep && !return_reg) begin
      repeat_reg <= ~repeat_reg;
    end
  end

  // size ring counter, held in automatic modes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      size_reg <= `SIZE_30;
    end else if (ev_size && !auto_mode) begin
      case (size_reg)
        `SIZE_30: size_reg <= `SIZE_25;
        `SIZE_25: size_reg <= `SIZE_17;
        default: size_reg <= `SIZE_30;
      endcase
    end
  end

  // end detector: delayed edge opens window, later edge inside it detects
  logic end_prev_reg, win_reg;
  logic [28:0] win_cnt_reg;
  logic [4:0] ed_cnt_reg;
  logic ed_pend_reg;
  wire end_rise = end_sensor_i & ~end_prev_reg;
  assign end_detect = end_rise & win_reg & ~lift_up_reg & ~return_reg;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      end_prev_reg <= 1'b0;
      win_reg <= 1'b0;
      win_cnt_reg <= 29'h0;
      ed_cnt_reg <= 5'h0;
      ed_pend_reg <= 1'b0;
    end else begin
      end_prev_reg <= end_sensor_i;
      if (lift_up_reg) begin
        win_reg <= 1'b0;
        ed_pend_reg <= 1'b0;
      end else begin
        if (end_rise) begin
          ed_pend_reg <= 1'b1; // slight delay before window
          ed_cnt_reg <= 5'h0;
        end else if (ed_pend_reg) begin
          ed_cnt_reg <= ed_cnt_reg + 5'h1;
          if (ed_cnt_reg == 5'(ED_MAX - 1)) begin
            ed_pend_reg <= 1'b0;
            win_reg <= 1'b1;
            win_cnt_reg <= 29'h0;
          end
        end
        if (win_reg && !(ed_pend_reg && ed_cnt_reg == 5'(ED_MAX - 1))) begin
          if (win_cnt_reg == 29'(WIN_MAX - 1)) win_reg <= 1'b0;
          win_cnt_reg <= step(win_cnt_reg);
        end
      end
    end
  end

  // registered outputs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lift_motor_up_o <= 1'b0;
      lift_motor_down_o <= 1'b0;
      lead_in_drive_o <= 1'b0;
      return_drive_o <= 1'b0;
      plunger_pulse_node_o <= 1'b0;
      platter_run_o <= 1'b0;
      locate_block_o <= 1'b0;
      size_sel_o <= `SIZE_30;
      leds_o <= '0;
    end else begin
      lift_motor_up_o <= lift_up_reg & ~lift_up_sw_i;
      lift_motor_down_o <= ~lift_up_reg & ~lift_lowered_i;
      lead_in_drive_o <= lead_in_reg & lift_up_sw_i;
      return_drive_o <= return_reg & lift_up_sw_i; // holds against rest too
      plunger_pulse_node_o <= plunger_reg;
      platter_run_o <= ~arm_at_rest_i;
      locate_block_o <= auto_mode | ~lift_up_sw_i;
      size_sel_o <= size_reg;
      leds_o.lift_up_ind <= lift_up_reg;
      leds_o.lift_down_ind <= ~lift_up_reg;
      leds_o.size30_ind <= (size_reg == `SIZE_30);
      leds_o.size25_ind <= (size_reg == `SIZE_25);
      leds_o.size17_ind <= (size_reg == `SIZE_17);
      leds_o.repeat_ind <= repeat_reg;
    end
  end

  // checks
  property p_lift_ind;
    @(posedge clock_i) disable iff (!rst_n_i) !(leds_o.lift_up_ind && leds_o.lift_down_ind);
  endproperty
  a_lift_ind: assert property (p_lift_ind) else $error("both lift indicators lit");
  property p_ret_set;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ev_ss && !ss_block_reg && !arm_at_rest_i && !descend) |=> return_reg && !repeat_reg;
  endproperty
  a_ret_set: assert property (p_ret_set) else $error("return not set by key");
  property p_no_plunger;
    @(posedge clock_i) disable iff (!rst_n_i)
      (size_cross && return_reg && !repeat_reg && !lead_in_reg && !plunger_reg) |=> !plunger_reg;
  endproperty
  a_no_plunger: assert property (p_no_plunger) else $error("plunger fired on plain return");
  property p_descend;
    @(posedge clock_i) disable iff (!rst_n_i) descend |=> !lift_up_reg && !return_reg && !lead_in_reg;
  endproperty
  a_descend: assert property (p_descend) else $error("descend did not lower lift");
  property p_size_hold;
    @(posedge clock_i) disable iff (!rst_n_i) auto_mode |=> $stable(size_reg) || !$past(auto_mode);
  endproperty
  a_size_hold: assert property (p_size_hold) else $error("size changed in auto mode");
  property p_win_up;
    @(posedge clock_i) disable iff (!rst_n_i) lift_up_reg |=> !win_reg;
  endproperty
  a_win_up: assert property (p_win_up) else $error("window open with lift up");
  property p_motor_up;
    @(posedge clock_i) disable iff (!rst_n_i) (lift_up_reg && !lift_up_sw_i) |=> lift_motor_up_o;
  endproperty
  a_motor_up: assert property (p_motor_up) else $error("lift not driven up");
  property p_motor_dn;
    @(posedge clock_i) disable iff (!rst_n_i) (!lift_up_reg && !lift_lowered_i) |=> lift_motor_down_o;
  endproperty
  a_motor_dn: assert property (p_motor_dn) else $error("lift not driven down");
  // carrier must not move back while the lift is still rising
  property p_ret_wait;
    @(posedge clock_i) disable iff (!rst_n_i) (return_reg && !lift_up_sw_i) |=> !return_drive_o;
  endproperty
  a_ret_wait: assert property (p_ret_wait) else $error("return drive before lift up");
  property p_platter_stop;
    @(posedge clock_i) disable iff (!rst_n_i) arm_at_rest_i |=> !platter_run_o;
  endproperty
  a_platter_stop: assert property (p_platter_stop) else $error("platter runs at rest");
  property p_end_set;
    @(posedge clock_i) disable iff (!rst_n_i) (end_detect && !descend) |=> return_reg;
  endproperty
  a_end_set: assert property (p_end_set) else $error("end detection did not start return");
  property p_replay;
    @(posedge clock_i) disable iff (!rst_n_i)
      (size_cross && return_reg && repeat_reg && !plunger_reg) |=> plunger_reg;
  endproperty
  a_replay: assert property (p_replay) else $error("plunger missed on repeat");
  property p_rep_frozen;
    @(posedge clock_i) disable iff (!rst_n_i)
      (return_reg && !ev_ss) |=> repeat_reg == $past(repeat_reg);
  endproperty
  a_rep_frozen: assert property (p_rep_frozen) else $error("repeat toggled during return");
  property p_lift_toggle;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ev_lift && !auto_mode && !descend) |=> lift_up_reg != $past(lift_up_reg);
  endproperty
  a_lift_toggle: assert property (p_lift_toggle) else $error("lift key did not toggle");
  property p_size_step;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ev_size && !auto_mode && size_reg == `SIZE_17) |=> size_reg == `SIZE_30;
  endproperty
  a_size_step: assert property (p_size_step) else $error("size ring did not wrap");
endmodule

// File: turntable_regs.svh
// timing counts and encodings for the full auto sequencer
`ifndef TURNTABLE_REGS_SVH
`define TURNTABLE_REGS_SVH
`define CLK_HZ 200000000
`define SS_BLOCK_DELAY_US 1000
`define SS_BLOCK_CYCLES ((`SS_BLOCK_DELAY_US * (`CLK_HZ / 1000000)))
`define END_WINDOW_MS 1060
`define END_WINDOW_CYCLES (`END_WINDOW_MS * (`CLK_HZ / 1000))
`define END_EDGE_DELAY_CYCLES 16
`define PLUNGER_MS 2200
`define PLUNGER_CYCLES (`PLUNGER_MS * (`CLK_HZ / 1000))
`define REST_HOLD_MS 500
`define REST_HOLD_CYCLES (`REST_HOLD_MS * (`CLK_HZ / 1000))
`define DEBOUNCE_US 10 // short hold so a press settles fast; raise it for panels with slow contact bounce
`define DEBOUNCE_CYCLES (`DEBOUNCE_US * (`CLK_HZ / 1000000))
`define SIZE_30 2'h0
`define SIZE_25 2'h1
`define SIZE_17 2'h2
`endif

// File: turntable_pkg.sv
// types shared by the full auto sequencer
package turntable_pkg;
  typedef struct packed {
    logic start_stop;
    logic lift;
    logic size;
    logic repeat_key;
  } keys_s;
  typedef struct packed {
    logic lift_up_ind;
    logic lift_down_ind;
    logic size30_ind;
    logic size25_ind;
    logic size17_ind;
    logic repeat_ind;
  } leds_s;
endpackage

// File: turntable_mech_model.sv
// mechanism model: lift travel, carrier position and its sensors
module turntable_mech_model #(
  parameter int LIFT_TRAVEL = 40, // cycles from fully down to fully up
  parameter int SIZE_POS = 100 // carrier position of the selected size sensor
) (
  input wire logic clock_i, // system clock
  input wire logic motor_up_i, // lift motor upward
  input wire logic motor_down_i, // lift motor downward
  input wire logic lead_in_i, // carrier toward record
  input wire logic return_i, // carrier toward rest
  input wire logic [1:0] hand_i, // 01 push away from rest, 10 push toward rest
  output logic lift_up_sw_o, // lift fully up
  output logic lift_lowered_o, // lift fully down
  output logic arm_at_rest_o, // carrier on the rest
  output logic size_sensor_o // shutter in the size sensor beam
);
  timeunit 1ns;
  timeprecision 100ps;
  int lift_pos = 0;
  int carrier_pos = 0;
  // lift starts fully down so the power-on rise is really travelled
  always @(posedge clock_i) begin
    if (motor_up_i && !motor_down_i && lift_pos < LIFT_TRAVEL) begin
      lift_pos <= lift_pos + 1;
    end else if (motor_down_i && !motor_up_i && lift_pos > 0) begin
      lift_pos <= lift_pos - 1;
    end
  end
  // carrier moves by drive or by hand; the rest stops it at zero
  always @(posedge clock_i) begin
    if (lead_in_i || hand_i == 2'h1) begin
      carrier_pos <= carrier_pos + 1;
    end else if ((return_i || hand_i == 2'h2) && carrier_pos > 0) begin
      carrier_pos <= carrier_pos - 1;
    end
  end
  // switches are pure position decodes, so mid-travel both read low
  assign lift_up_sw_o = (lift_pos == LIFT_TRAVEL);
  assign lift_lowered_o = (lift_pos == 0);
  assign arm_at_rest_o = (carrier_pos == 0);
  assign size_sensor_o = (carrier_pos == SIZE_POS);
endmodule

// File: turntable_full_auto_sequencer_tb.sv
// self-checking bench for the full auto sequencer
`define CHECK_EQ(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module turntable_full_auto_sequencer_tb;
  import turntable_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
`include "turntable_regs.svh"
  localparam int DB = `DEBOUNCE_CYCLES;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  keys_s keys = '0;
  logic end_sensor = 1'b0;
  logic [1:0] hand = 2'h0;
  logic lift_up_sw, lift_lowered, arm_at_rest, size_sensor;
  logic lift_motor_up, lift_motor_down, lead_in_drive, return_drive, plunger, platter_run, locate_block;
  logic [1:0] size_sel;
  leds_s leds;
  int err_total = 0;
  int num_checks = 0;
  // clock at 200 MHz
  initial begin
    forever #2.5 clk = ~clk;
  end
  turntable_full_auto_sequencer DUT (.clock_i(clk), .rst_n_i(rst_n), .keys_i(keys),
    .arm_at_rest_i(arm_at_rest), .lift_up_sw_i(lift_up_sw), .lift_lowered_i(lift_lowered),
    .size_sensor_i(size_sensor), .end_sensor_i(end_sensor), .lift_motor_up_o(lift_motor_up),
    .lift_motor_down_o(lift_motor_down), .lead_in_drive_o(lead_in_drive), .return_drive_o(return_drive),
    .plunger_pulse_node_o(plunger), .platter_run_o(platter_run), .locate_block_o(locate_block),
    .size_sel_o(size_sel), .leds_o(leds));
  turntable_mech_model mech (.clock_i(clk), .motor_up_i(lift_motor_up), .motor_down_i(lift_motor_down),
    .lead_in_i(lead_in_drive), .return_i(return_drive), .hand_i(hand), .lift_up_sw_o(lift_up_sw),
    .lift_lowered_o(lift_lowered), .arm_at_rest_o(arm_at_rest), .size_sensor_o(size_sensor));
  // verdict and end of run
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // advance n cycles and sample a moment after the edge settles
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic probe(input int sel);
    case (sel)
      0: return lift_up_sw;
      1: return platter_run;
      3: return return_drive;
      4: return plunger;
      default: return arm_at_rest;
    endcase
  endfunction
  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_until(input int sel, input logic v, input int limit);
    int i;
    for (i = 0; i < limit; i++) begin
      if (probe(sel) === v) return;
      cycles(1);
    end
    err_total++;
    $display("MISMATCH t=%0t wait %0d timed out got=%h exp=%h", $time, sel, probe(sel), v);
    conclude();
  endtask
  // reset held 8 cycles; outputs dark during reset, power-on state after
  task automatic power_on();
    @(posedge clk) rst_n <= 1'b0;
    cycles(7);
    `CHECK_EQ(leds, 6'h00)
    `CHECK_EQ(return_drive, 1'b0)
    @(posedge clk) rst_n <= 1'b1;
    cycles(3);
    `CHECK_EQ(leds, 6'h28)
    `CHECK_EQ(size_sel, 2'h0)
    `CHECK_EQ(return_drive, 1'b0)
    `CHECK_EQ(lead_in_drive, 1'b0)
    `CHECK_EQ(plunger, 1'b0)
    `CHECK_EQ(lift_motor_down, 1'b0)
    $display("test power_on done");
  endtask
  // one clean key press: held past the debounce, then released past it
  task automatic press(input int idx);
    @(posedge clk) keys <= keys_s'(4'h1 << idx);
    cycles(DB + 8);
    @(posedge clk) keys <= '0;
    cycles(DB + 8);
  endtask
  // carrier pushed by hand for n cycles
  task automatic push(input logic [1:0] dir, input int n);
    @(posedge clk) hand <= dir;
    cycles(n);
    @(posedge clk) hand <= 2'h0;
  endtask
  // a lone edge only opens the window; a second edge inside it detects the end
  task automatic end_edges();
    @(posedge clk) end_sensor <= 1'b1;
    cycles(40);
    `CHECK_EQ(leds.lift_down_ind, 1'b1)
    `CHECK_EQ(return_drive, 1'b0)
    @(posedge clk) end_sensor <= 1'b0;
    cycles(4);
    @(posedge clk) end_sensor <= 1'b1;
    cycles(4);
    `CHECK_EQ(leds.lift_up_ind, 1'b1)
    `CHECK_EQ(locate_block, 1'b1)
    `CHECK_EQ(return_drive, 1'b0)
    wait_until(3, 1'b1, 100);
    `CHECK_EQ(return_drive, 1'b1)
    @(posedge clk) end_sensor <= 1'b0;
  endtask
  initial begin
    int k;
    power_on();
    // lift starts down: up-drive until the up switch, then off
    if (lift_up_sw !== 1'b1) begin
      `CHECK_EQ(lift_motor_up, 1'b1)
    end
    wait_until(0, 1'b1, 200);
    cycles(4);
    `CHECK_EQ(lift_motor_up, 1'b0)
    `CHECK_EQ(lift_motor_down, 1'b0)
    $display("test lift_rise done");
    // arm moved off rest by hand starts the platter
    @(posedge clk) hand <= 2'h1;
    cycles(30);
    @(posedge clk) hand <= 2'h0;
    wait_until(1, 1'b1, 20);
    `CHECK_EQ(platter_run, 1'b1)
    $display("test off_rest done");
    // fast end-sensor edges while lift is up must not start a return
    for (k = 0; k < 8; k++) begin
      @(posedge clk) end_sensor <= ~end_sensor;
      cycles(20);
    end
    cycles(60);
    `CHECK_EQ(return_drive, 1'b0)
    `CHECK_EQ(leds.lift_up_ind, 1'b1)
    `CHECK_EQ(locate_block, 1'b0)
    $display("test end_inhibit done");
    // short key blips are bounce and change nothing
    for (k = 0; k < 4; k++) begin
      @(posedge clk) keys <= keys_s'(4'h1 << k);
      cycles(100);
      @(posedge clk) keys <= '0;
      cycles(100);
      `CHECK_EQ(leds, 6'h28)
      `CHECK_EQ(size_sel, 2'h0)
      `CHECK_EQ(return_drive, 1'b0)
    end
    $display("test key_bounce done");
    // arm pushed back onto the rest stops the platter
    @(posedge clk) hand <= 2'h2;
    wait_until(2, 1'b1, 100);
    @(posedge clk) hand <= 2'h0;
    wait_until(1, 1'b0, 20);
    `CHECK_EQ(platter_run, 1'b0)
    $display("test back_to_rest done");
    // lift key lowers the arm; end edges then start a plain return
    press(2);
    `CHECK_EQ(leds.lift_down_ind, 1'b1)
    `CHECK_EQ(leds.lift_up_ind, 1'b0)
    `CHECK_EQ(lift_lowered, 1'b1)
    push(2'h1, 150);
    end_edges();
    wait_until(2, 1'b1, 300);
    `CHECK_EQ(plunger, 1'b0)
    wait_until(1, 1'b0, 20);
    `CHECK_EQ(platter_run, 1'b0)
    `CHECK_EQ(return_drive, 1'b1)
    press(1);
    `CHECK_EQ(size_sel, `SIZE_30)
    press(0);
    `CHECK_EQ(leds.repeat_ind, 1'b0)
    $display("test plain_return done");
    // second reset in mid-run restores the power-on state
    power_on();
    // size ring, repeat on, then an end detection replays through the plunger
    press(1);
    `CHECK_EQ(size_sel, `SIZE_25)
    `CHECK_EQ(leds, 6'h24)
    press(1);
    `CHECK_EQ(size_sel, `SIZE_17)
    press(1);
    `CHECK_EQ(size_sel, `SIZE_30)
    press(0);
    `CHECK_EQ(leds.repeat_ind, 1'b1)
    press(2);
    push(2'h1, 150);
    end_edges();
    `CHECK_EQ(leds.repeat_ind, 1'b1)
    wait_until(4, 1'b1, 200);
    `CHECK_EQ(plunger, 1'b1)
    $display("test repeat_replay done");
    power_on();
    // start/stop off rest starts a return and clears repeat
    press(0);
    `CHECK_EQ(leds.repeat_ind, 1'b1)
    push(2'h1, 30);
    press(3);
    `CHECK_EQ(leds.repeat_ind, 1'b0)
    `CHECK_EQ(return_drive, 1'b1)
    `CHECK_EQ(locate_block, 1'b1)
    `CHECK_EQ(platter_run, 1'b0)
    $display("test stop_return done");
    conclude();
  end
endmodule
